/* common/pmbp_pkg.sv */
// Constants, types and config layout for the program memory block guard.
// Assumes a single core clock domain and byte-wide program memory.
package pmbp_pkg;

	// ------------------------------------------------------------------
	// Address space
	// ------------------------------------------------------------------
	typedef logic [21:0] pmbp_addr_t;

	localparam pmbp_addr_t CFG_CP_LO = 22'h30_0008;
	localparam pmbp_addr_t CFG_CP_HI = 22'h30_0009;
	localparam pmbp_addr_t CFG_WP_LO = 22'h30_000A;
	localparam pmbp_addr_t CFG_WP_HI = 22'h30_000B;
	localparam pmbp_addr_t CFG_TR_LO = 22'h30_000C;
	localparam pmbp_addr_t CFG_TR_HI = 22'h30_000D;
	localparam pmbp_addr_t DEVID1_ADDR = 22'h3F_FFFE;
	localparam pmbp_addr_t DEVID2_ADDR = 22'h3F_FFFF;
	localparam pmbp_addr_t IDLOC_FIRST = 22'h20_0000;
	localparam pmbp_addr_t IDLOC_LAST = 22'h20_0007;

	localparam pmbp_addr_t LIMIT_8K = 22'h00_2000;
	localparam pmbp_addr_t LIMIT_16K = 22'h00_4000;
	localparam pmbp_addr_t LIMIT_32K = 22'h00_8000;
	localparam pmbp_addr_t LIMIT_64K = 22'h01_0000;
	localparam pmbp_addr_t BOOT_END_SMALL = 22'h00_01FF;
	localparam pmbp_addr_t BOOT_END_LARGE = 22'h00_07FF;

	// Block index bit in the address, per memory size
	localparam int BLK_SEL_8K = 12;
	localparam int BLK_SEL_32K = 13;
	localparam int BLK_SEL_64K = 14;

	// ------------------------------------------------------------------
	// Config byte fields
	// ------------------------------------------------------------------
	localparam int BIT_EEPROM = 7;
	localparam int BIT_BOOT = 6;
	localparam int BIT_CFG_WP = 5;
	localparam logic [7:0] MASK_LO_SMALL = 8'h03;
	localparam logic [7:0] MASK_LO_LARGE = 8'h0F;
	localparam logic [7:0] MASK_CP_HI = 8'hC0;
	localparam logic [7:0] MASK_WP_HI = 8'hE0;
	localparam logic [7:0] MASK_TR_HI = 8'h40;
	localparam logic [7:0] CFG_ERASED = 8'hFF;

	localparam logic [2:0] BLK_BOOT = 3'h4;
	localparam logic [2:0] BLK_NONE = 3'h7;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SZ_8K = 2'b00,
		SZ_16K = 2'b01,
		SZ_32K = 2'b10,
		SZ_64K = 2'b11
	} pmbp_size_e;

	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_CHIP_ERASE = 2'b10,
		OP_BLK_ERASE = 2'b11
	} pmbp_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEM = 2'b01,
		ST_WAIT = 2'b10,
		ST_ANS = 2'b11
	} pmbp_state_e;

	typedef struct packed {
		pmbp_op_e op;
		pmbp_addr_t addr;
		pmbp_addr_t pc;
		logic [7:0] wdata;
		logic ext;
	} pmbp_req_s;

endpackage

/* dv/pmbp_flash_model.sv */
// Flash array stand-in for the guard's far side.
// Assumes one core clock; read data is valid the cycle after a strobe.
`timescale 1ns/10ps
module pmbp_flash_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic [21:0] addr_i,
	output logic [7:0] rdata_o
);
	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	// Data is a pattern of the address; between reads the bus toggles
	// so a late sample never sees a stale but plausible byte
	initial rdata_o = 8'h00;
	always @(posedge clk_i)
	begin
		if (req_i && !wr_i)
			rdata_o <= addr_i[7:0] ^ 8'hA5;
		else
			rdata_o <= ~rdata_o;
	end
endmodule

/* dv/pmbp_guard_assertions.sv */
// Checker for the program memory block guard, bound to its ports.
// Assumes a single core clock and the active high reset.
`timescale 1ns/10ps
module pmbp_guard_chk
	import pmbp_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic [1:0] PRG_OP_I,
	input wire logic PRG_REQ_I,
	input wire logic CPU_ACK_O,
	input wire logic [7:0] CPU_RDATA_O,
	input wire logic PRG_ACK_O,
	input wire logic FL_REQ_O,
	input wire logic FL_WR_O,
	input wire logic [21:0] FL_ADDR_O,
	input wire logic [7:0] FL_RDATA_I,
	input wire logic FL_CHIP_ERASE_O,
	input wire logic FL_BLK_ERASE_O,
	input wire logic EE_EXT_BLOCK_O,
	input wire logic EE_WR_BLOCK_O
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	logic any_ack;
	assign any_ack = CPU_ACK_O || PRG_ACK_O;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	sequence fl_read;
		FL_REQ_O && !FL_WR_O;
	endsequence
	sequence answer;
		CPU_ACK_O || PRG_ACK_O;
	endsequence
	flash_answer_a: assert property (FL_REQ_O |-> ##2 answer)
		else $error("no answer two cycles after flash strobe");
	read_path_a: assert property (fl_read ##2 answer |->
		CPU_RDATA_O == $past(FL_RDATA_I))
		else $error("read data is not the flash data");
	strobe_pulse_a: assert property (FL_REQ_O |=>
		!FL_REQ_O && $stable(FL_ADDR_O))
		else $error("flash strobe longer than one cycle");
	chip_erase_src_a: assert property (FL_CHIP_ERASE_O |->
		PRG_ACK_O && PRG_REQ_I && PRG_OP_I == OP_CHIP_ERASE)
		else $error("chip erase without programmer request");
	block_erase_src_a: assert property (FL_BLK_ERASE_O |->
		PRG_ACK_O && PRG_REQ_I && PRG_OP_I == OP_BLK_ERASE)
		else $error("block erase without programmer request");
	write_range_a: assert property (FL_REQ_O && FL_WR_O |->
		FL_ADDR_O < LIMIT_64K ||
		FL_ADDR_O inside {[IDLOC_FIRST:IDLOC_LAST]})
		else $error("flash write outside memory");
	answer_pulse_a: assert property (answer |=> !any_ack)
		else $error("answer longer than one cycle");
	rdata_hold_a: assert property (!any_ack |-> $stable(CPU_RDATA_O))
		else $error("read data changed without answer");
	erase_ee_free_a: assert property (FL_CHIP_ERASE_O |->
		##[0:2] (!EE_EXT_BLOCK_O && !EE_WR_BLOCK_O))
		else $error("eeprom still blocked after chip erase");
endmodule
bind pmbp_guard pmbp_guard_chk u_chk (.*);

/* dv/program_memory_block_protection_test.sv */
// Testbench for the program memory block guard.
// Assumes the flash model answers the cycle after each strobe.
`timescale 1ns/10ps
module program_memory_block_protection_test
	import pmbp_pkg::*;
();
	localparam logic C = 1'b0;
	localparam logic P = 1'b1;
	// Arbitrary identity values
	localparam logic [7:0] ID1 = 8'h3C;
	localparam logic [7:0] ID2 = 8'hC3;
	logic clk, rst, creq, cwr, cack, preq, pack, freq, fwr, fce, fbe;
	logic eex, ewr;
	logic [21:0] cadr, cpc, padr, fadr;
	logic [7:0] cwd, crd, pwd, prd, fwd, frd;
	logic [1:0] sz, pop;
	int miscompares, n_compared;

	// ------------------------------------------------------------------
	// Structure
	// ------------------------------------------------------------------
	pmbp_guard #(.DEVID1_VAL(ID1), .DEVID2_VAL(ID2)) u_dut (
		.CLK_SYS_I(clk), .RST_I(rst), .MEM_SIZE_I(sz),
		.CPU_REQ_I(creq), .CPU_WR_I(cwr), .CPU_ADDR_I(cadr),
		.CPU_PC_I(cpc), .CPU_WDATA_I(cwd), .CPU_ACK_O(cack),
		.CPU_RDATA_O(crd), .PRG_REQ_I(preq), .PRG_OP_I(pop),
		.PRG_ADDR_I(padr), .PRG_WDATA_I(pwd), .PRG_ACK_O(pack),
		.PRG_RDATA_O(prd), .FL_REQ_O(freq), .FL_WR_O(fwr),
		.FL_ADDR_O(fadr), .FL_WDATA_O(fwd), .FL_RDATA_I(frd),
		.FL_CHIP_ERASE_O(fce), .FL_BLK_ERASE_O(fbe),
		.EE_EXT_BLOCK_O(eex), .EE_WR_BLOCK_O(ewr));
	pmbp_flash_model u_fl (.clk_i(clk), .req_i(freq), .wr_i(fwr),
		.addr_i(fadr), .rdata_o(frd));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	function automatic logic [7:0] fx(input logic [21:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction

	// One access; ef of FF leaves the strobe count unchecked
	task t(input logic p, input logic [1:0] op, input logic [21:0] a,
		input logic [21:0] pc, input logic [7:0] wd,
		input logic [7:0] e, input logic [7:0] ef);
		logic [7:0] fl;
		logic [7:0] er;
		logic ok;
		fl = 8'h00;
		er = 8'h00;
		ok = 1'b0;
		@(posedge clk);
		if (p)
		begin
			preq <= 1'b1;
			pop <= op;
			padr <= a;
			pwd <= wd;
		end
		else
		begin
			creq <= 1'b1;
			cwr <= op[0];
			cadr <= a;
			cpc <= pc;
			cwd <= wd;
		end
		for (int n = 0; n < 10 && !ok; n++)
		begin
			@(negedge clk);
			fl = fl + {7'h00, freq};
			er = er | {6'h00, fce, fbe};
			if (freq === 1'b1 && fwr === 1'b1)
				chk(fwd, wd);
			ok = (p ? pack : cack) === 1'b1;
		end
		@(posedge clk);
		preq <= 1'b0;
		creq <= 1'b0;
		chk({7'h00, ok}, 8'h01);
		if (op == OP_READ)
			chk(p ? prd : crd, e);
		if (ef !== 8'hFF)
			chk(fl, ef);
		chk(er, {6'h00, op == OP_CHIP_ERASE, op == OP_BLK_ERASE});
	endtask

	task conclude;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task s_reset;
		logic [7:0] rv [6];
		rv = '{8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
		for (int i = 0; i < 6; i++)
			t(C, OP_READ, CFG_CP_LO + 22'(i), '0, '0, rv[i], 0);
		sz <= SZ_8K;
		t(C, OP_READ, CFG_CP_LO, '0, '0, 8'h03, 0);
		t(C, OP_READ, 22'h00_1FFF, '0, '0, fx(22'h00_1FFF), 1);
		t(C, OP_READ, 22'h00_2000, '0, '0, 8'h00, 0);
		sz <= SZ_16K;
		t(C, OP_READ, 22'h00_3FFF, '0, '0, fx(22'h00_3FFF), 1);
		t(C, OP_READ, 22'h00_4000, '0, '0, 8'h00, 0);
		sz <= SZ_32K;
		t(C, OP_READ, 22'h00_7FFF, '0, '0, fx(22'h00_7FFF), 1);
		t(C, OP_READ, 22'h00_8000, '0, '0, 8'h00, 0);
		t(C, OP_READ, CFG_WP_LO, '0, '0, 8'h0F, 0);
		sz <= SZ_64K;
		t(C, OP_READ, 22'h01_0000, '0, '0, 8'h00, 0);
		t(C, OP_READ, DEVID1_ADDR, '0, '0, ID1, 0);
		t(P, OP_READ, DEVID2_ADDR, '0, '0, ID2, 0);
		t(C, OP_READ, IDLOC_FIRST, '0, '0, fx(IDLOC_FIRST), 1);
	endtask

	task s_trp;
		t(C, OP_WRITE, CFG_TR_LO, '0, 8'hFE, '0, 0);
		t(C, OP_READ, 22'h00_0800, 22'h00_3FFF, '0, fx(22'h00_0800), 1);
		t(C, OP_READ, 22'h00_0800, 22'h00_07FF, '0, 8'h00, 0);
		t(P, OP_READ, 22'h00_0800, '0, '0, fx(22'h00_0800), 1);
		t(C, OP_WRITE, CFG_TR_LO, '0, 8'hFF, '0, 0);
		t(C, OP_READ, CFG_TR_LO, '0, '0, 8'h0E, 0);
		t(C, OP_WRITE, CFG_TR_HI, '0, 8'h00, '0, 0);
		t(C, OP_READ, 22'h00_0100, 22'h00_0800, '0, 8'h00, 0);
		t(C, OP_READ, 22'h00_0100, 22'h00_0010, '0, fx(22'h00_0100), 1);
	endtask

	task s_wp;
		t(C, OP_WRITE, CFG_WP_LO, '0, 8'hFD, '0, 0);
		t(C, OP_WRITE, 22'h00_4000, '0, 8'h11, '0, 0);
		t(C, OP_WRITE, 22'h00_8000, '0, 8'h22, '0, 1);
		t(P, OP_WRITE, 22'h00_4000, '0, 8'h33, '0, 1);
	endtask

	task s_cp;
		t(C, OP_WRITE, CFG_CP_LO, '0, 8'hFB, '0, 0);
		t(C, OP_READ, 22'h00_8000, '0, '0, fx(22'h00_8000), 1);
		t(P, OP_READ, 22'h00_8000, '0, '0, 8'h00, 0);
		t(P, OP_WRITE, 22'h00_8000, '0, 8'h44, '0, 0);
	endtask

	task s_lock;
		t(C, OP_WRITE, CFG_WP_HI, '0, 8'h00, '0, 0);
		t(C, OP_READ, CFG_WP_HI, '0, '0, 8'h20, 0);
		@(negedge clk);
		chk({7'h00, ewr}, 8'h01);
		t(P, OP_WRITE, CFG_WP_HI, '0, 8'hC0, '0, 0);
		t(C, OP_WRITE, CFG_CP_LO, '0, 8'h00, '0, 0);
		t(C, OP_READ, CFG_CP_LO, '0, '0, 8'h0B, 0);
		t(P, OP_WRITE, CFG_CP_HI, '0, 8'h40, '0, 0);
		@(negedge clk);
		chk({7'h00, eex}, 8'h01);
	endtask

	// Erases come from the programmer side only
	task s_erase;
		t(P, OP_BLK_ERASE, 22'h00_8000, '0, '0, '0, 0);
		t(C, OP_READ, CFG_CP_LO, '0, '0, 8'h0F, 0);
		t(C, OP_READ, CFG_WP_LO, '0, '0, 8'h0D, 0);
		t(P, OP_CHIP_ERASE, '0, '0, '0, '0, 0);
		t(C, OP_READ, CFG_WP_HI, '0, '0, 8'hE0, 0);
		@(negedge clk);
		chk({6'h00, eex, ewr}, 8'h00);
	endtask

	initial
	begin
		rst = 1'b1;
		sz = SZ_64K;
		{creq, cwr, preq} = '0;
		{cadr, cpc, padr} = '0;
		{cwd, pwd, pop} = '0;
		miscompares = 0;
		n_compared = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		s_reset;
		s_trp;
		s_wp;
		s_cp;
		s_lock;
		s_erase;
		conclude;
	end

	// Whole run is a few hundred cycles; this is far beyond it
	initial
	begin
		#400000;
		miscompares++;
		conclude;
	end
endmodule

/* verilog/pmbp_guard.sv */
// Program memory block guard: filters table and programmer accesses.
// Assumes requesters hold their request until the answer pulse and the
// flash array returns read data the cycle after its request strobe.
//
// How it works
// - Memory splits into a boot block plus numbered blocks; boot 0.5K or 2K.
// - Each block has code-protect, write-protect and table-read-protect bits.
// - 8K: boot 000-1FF, block0 200-FFF, block1 1000-1FFF, rest reads zero.
// - 16K/32K: boot 000-7FF, blocks of 8K; 32K adds blocks 2 and 3.
// - 64K: boot 000-7FF, blocks of 16K; above FFFF reads zero.
// - Six config bytes at 300008..30000D: code, write, table-read, lo/hi.
// - Low bytes hold blocks 3..0; boot bit 6, eeprom bit 7, config bit 5.
// - Block 2 and 3 bits exist only on 32K and 64K sizes.
// - Running code cannot change the config write-protect bit.
// - Table access reaches all program memory, device ID and config bytes.
// - Code-protect blocks only programmer-port reads and writes.
// - Write-protect cleared refuses table writes into that block.
// - Table read from inside a read-protected block sees true data.
// - Table read from outside a read-protected block returns zeros.
// - Protection bits only go from one to zero when written.
// - Protection bits return to one only by reset or by chip or block erase.
// - Erases are accepted only from the programmer port.
// - Eeprom code bit blocks external access; write bit blocks all writes.
// - Bit value one means unprotected, zero means protected.
`timescale 1ns/10ps
module pmbp_guard
	import pmbp_pkg::*;
#(
	parameter logic [7:0] DEVID1_VAL = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEVID2_VAL = 8'hA5 // Arbitrary value
)(
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic [1:0] MEM_SIZE_I,
	input wire logic CPU_REQ_I,
	input wire logic CPU_WR_I,
	input wire logic [21:0] CPU_ADDR_I,
	input wire logic [21:0] CPU_PC_I,
	input wire logic [7:0] CPU_WDATA_I,
	output logic CPU_ACK_O,
	output logic [7:0] CPU_RDATA_O,
	input wire logic PRG_REQ_I,
	input wire logic [1:0] PRG_OP_I,
	input wire logic [21:0] PRG_ADDR_I,
	input wire logic [7:0] PRG_WDATA_I,
	output logic PRG_ACK_O,
	output logic [7:0] PRG_RDATA_O,
	output logic FL_REQ_O,
	output logic FL_WR_O,
	output logic [21:0] FL_ADDR_O,
	output logic [7:0] FL_WDATA_O,
	input wire logic [7:0] FL_RDATA_I,
	output logic FL_CHIP_ERASE_O,
	output logic FL_BLK_ERASE_O,
	output logic EE_EXT_BLOCK_O,
	output logic EE_WR_BLOCK_O
);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	// Block index of an address; BLK_NONE past the implemented end
	function automatic logic [2:0] block_of(input pmbp_addr_t a,
		input pmbp_size_e sz);
		logic [2:0] b;
		b = BLK_NONE;
		unique case (sz)
			SZ_8K:
			begin
				if (a <= BOOT_END_SMALL) b = BLK_BOOT;
				else if (a < LIMIT_8K) b = {2'b00, a[BLK_SEL_8K]};
			end
			SZ_16K:
			begin
				if (a <= BOOT_END_LARGE) b = BLK_BOOT;
				else if (a < LIMIT_16K) b = {2'b00, a[BLK_SEL_32K]};
			end
			SZ_32K:
			begin
				if (a <= BOOT_END_LARGE) b = BLK_BOOT;
				else if (a < LIMIT_32K)
					b = {1'b0, a[BLK_SEL_32K+1:BLK_SEL_32K]};
			end
			SZ_64K:
			begin
				if (a <= BOOT_END_LARGE) b = BLK_BOOT;
				else if (a < LIMIT_64K)
					b = {1'b0, a[BLK_SEL_64K+1:BLK_SEL_64K]};
			end
		endcase
		return b;
	endfunction

	// One protection bit of a lo/hi pair for a block index
	function automatic logic prot_of(input logic [7:0] lo,
		input logic [7:0] hi, input logic [2:0] b);
		logic p;
		p = 1'b1;
		if (b == BLK_BOOT) p = hi[BIT_BOOT];
		else if (b != BLK_NONE) p = lo[b[1:0]];
		return p;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	pmbp_state_e st_r, st_nxt;
	pmbp_req_s req_r, req_nxt;
	pmbp_size_e size_r;
	logic [7:0] cfg_r [6];
	logic [7:0] cfg_nxt [6];
	logic [7:0] rdata_r, rdata_nxt;
	logic cpu_ack_r, cpu_ack_nxt, prg_ack_r, prg_ack_nxt;
	logic fl_req_r, fl_req_nxt, fl_wr_r, fl_wr_nxt;
	logic chip_er_r, chip_er_nxt, blk_er_r, blk_er_nxt;
	logic [7:0] lo_mask;
	logic [7:0] cfg_mask [6];
	logic [7:0] cfg_view [6];
	pmbp_req_s in_req;
	logic [2:0] tgt_blk, own_blk;
	logic in_cfg, in_id, in_dev;
	logic [2:0] cfg_idx;
	logic p_cp, p_wp, p_tr, config_write_protect;

	// Blocks 2 and 3 only exist on the larger parts
	assign lo_mask = (size_r == SZ_32K || size_r == SZ_64K) ?
		MASK_LO_LARGE : MASK_LO_SMALL;
	assign cfg_mask[0] = lo_mask;
	assign cfg_mask[1] = MASK_CP_HI;
	assign cfg_mask[2] = lo_mask;
	assign cfg_mask[3] = MASK_WP_HI;
	assign cfg_mask[4] = lo_mask;
	assign cfg_mask[5] = MASK_TR_HI;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_view
			// Unimplemented bits read as zero
			assign cfg_view[gi] = cfg_r[gi] & cfg_mask[gi];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Request decode; programmer wins when both ask at once
	// ------------------------------------------------------------------
	always_comb
	begin
		in_req = req_r;
		if (st_r == ST_IDLE)
		begin
			if (PRG_REQ_I)
				in_req = '{op: pmbp_op_e'(PRG_OP_I), addr: PRG_ADDR_I,
					pc: PRG_ADDR_I, wdata: PRG_WDATA_I, ext: 1'b1};
			else
				in_req = '{op: CPU_WR_I ? OP_WRITE : OP_READ,
					addr: CPU_ADDR_I, pc: CPU_PC_I,
					wdata: CPU_WDATA_I, ext: 1'b0};
		end
	end

	assign tgt_blk = block_of(in_req.addr, size_r);
	assign own_blk = block_of(in_req.pc, size_r);
	assign in_cfg = in_req.addr >= CFG_CP_LO && in_req.addr <= CFG_TR_HI;
	assign cfg_idx = 3'(in_req.addr - CFG_CP_LO);
	assign in_id = in_req.addr >= IDLOC_FIRST && in_req.addr <= IDLOC_LAST;
	assign in_dev = in_req.addr == DEVID1_ADDR || in_req.addr == DEVID2_ADDR;
	assign p_cp = prot_of(cfg_r[0], cfg_r[1], tgt_blk);
	assign p_wp = prot_of(cfg_r[2], cfg_r[3], tgt_blk);
	assign p_tr = prot_of(cfg_r[4], cfg_r[5], tgt_blk);
	assign config_write_protect = cfg_r[3][BIT_CFG_WP];

	// ------------------------------------------------------------------
	// Access sequencer and config bytes
	// ------------------------------------------------------------------
	always_comb
	begin
		logic go, mem_ok, is_rd;
		logic [7:0] keep;
		go = 1'b0;
		mem_ok = 1'b0;
		is_rd = 1'b0;
		keep = 8'h00;
		st_nxt = st_r;
		req_nxt = req_r;
		cfg_nxt = cfg_r;
		rdata_nxt = rdata_r;
		cpu_ack_nxt = 1'b0;
		prg_ack_nxt = 1'b0;
		fl_req_nxt = 1'b0;
		fl_wr_nxt = fl_wr_r;
		chip_er_nxt = 1'b0;
		blk_er_nxt = 1'b0;
		unique case (st_r)
			ST_IDLE:
			begin
				go = PRG_REQ_I | CPU_REQ_I;
				is_rd = in_req.op == OP_READ;
				if (go)
				begin
					req_nxt = in_req;
					rdata_nxt = 8'h00; // Gaps read zero
					st_nxt = ST_ANS;
					cpu_ack_nxt = ~in_req.ext;
					prg_ack_nxt = in_req.ext;
					if (in_req.op == OP_CHIP_ERASE)
					begin
						// Only the programmer encodes erase ops
						for (int i = 0; i < 6; i++)
							cfg_nxt[i] = CFG_ERASED;
						chip_er_nxt = 1'b1;
					end
					else if (in_req.op == OP_BLK_ERASE)
					begin
						if (tgt_blk != BLK_NONE)
						begin
							for (int i = 0; i < 6; i++)
							begin
								if (tgt_blk == BLK_BOOT && i[0])
									cfg_nxt[i][BIT_BOOT] = 1'b1;
								else if (tgt_blk != BLK_BOOT && !i[0])
									cfg_nxt[i][tgt_blk[1:0]] = 1'b1;
							end
							blk_er_nxt = 1'b1;
						end
					end
					else if (in_cfg)
					begin
						if (is_rd)
							rdata_nxt = cfg_view[cfg_idx];
						else if (in_req.ext || config_write_protect)
						begin
							// Running code may never touch the lock bit
							keep[BIT_CFG_WP] = !in_req.ext &&
								cfg_idx == 3'd3;
							cfg_nxt[cfg_idx] = cfg_r[cfg_idx] &
								(in_req.wdata | keep);
						end
					end
					else if (in_dev)
					begin
						if (is_rd)
							rdata_nxt = in_req.addr[0] ?
								DEVID2_VAL : DEVID1_VAL;
					end
					else if (in_id)
						mem_ok = 1'b1;
					else if (tgt_blk != BLK_NONE)
					begin
						if (in_req.ext)
							mem_ok = p_cp;
						else if (is_rd)
							mem_ok = p_tr || own_blk == tgt_blk;
						else
							mem_ok = p_wp;
					end
					if (mem_ok)
					begin
						// Refused accesses still answer, with zero data
						st_nxt = ST_MEM;
						// Old data stands until the flash answers
						rdata_nxt = rdata_r;
						cpu_ack_nxt = 1'b0;
						prg_ack_nxt = 1'b0;
						fl_req_nxt = 1'b1;
						fl_wr_nxt = ~is_rd;
					end
				end
			end
			ST_MEM:
				st_nxt = ST_WAIT;
			ST_WAIT:
			begin
				if (!fl_wr_r)
					rdata_nxt = FL_RDATA_I;
				st_nxt = ST_ANS;
				cpu_ack_nxt = ~req_r.ext;
				prg_ack_nxt = req_r.ext;
			end
			ST_ANS:
				st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_r <= ST_IDLE;
			req_r <= '0;
			for (int i = 0; i < 6; i++)
				cfg_r[i] <= CFG_ERASED; // Erased means open
			rdata_r <= 8'h00;
			cpu_ack_r <= 1'b0;
			prg_ack_r <= 1'b0;
			fl_req_r <= 1'b0;
			fl_wr_r <= 1'b0;
			chip_er_r <= 1'b0;
			blk_er_r <= 1'b0;
			size_r <= SZ_64K;
		end
		else
		begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
			cpu_ack_r <= cpu_ack_nxt;
			prg_ack_r <= prg_ack_nxt;
			fl_req_r <= fl_req_nxt;
			fl_wr_r <= fl_wr_nxt;
			chip_er_r <= chip_er_nxt;
			blk_er_r <= blk_er_nxt;
			size_r <= pmbp_size_e'(MEM_SIZE_I);
		end
	end

	// ------------------------------------------------------------------
	// Eeprom gates, registered
	// ------------------------------------------------------------------
	logic ee_ext_r, ee_wr_r;

	always_ff @(posedge CLK_SYS_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ee_ext_r <= 1'b0;
			ee_wr_r <= 1'b0;
		end
		else
		begin
			ee_ext_r <= ~cfg_r[1][BIT_EEPROM];
			ee_wr_r <= ~cfg_r[3][BIT_EEPROM];
		end
	end

	assign CPU_ACK_O = cpu_ack_r;
	assign PRG_ACK_O = prg_ack_r;
	assign CPU_RDATA_O = rdata_r;
	assign PRG_RDATA_O = rdata_r;
	assign FL_REQ_O = fl_req_r;
	assign FL_WR_O = fl_wr_r;
	assign FL_ADDR_O = req_r.addr;
	assign FL_WDATA_O = req_r.wdata;
	assign FL_CHIP_ERASE_O = chip_er_r;
	assign FL_BLK_ERASE_O = blk_er_r;
	assign EE_EXT_BLOCK_O = ee_ext_r;
	assign EE_WR_BLOCK_O = ee_wr_r;

endmodule
